// ### add_sub_cfg.svh
// Constants of the binary and decimal add and subtract unit.
`ifndef ADD_SUB_CFG_SVH
`define ADD_SUB_CFG_SVH
`define OPC_W            12
`define OPC_ADD          12'h0400
`define OPC_ADD_L        12'h0401
`define OPC_ADD_C        12'h0402
`define OPC_ADD_CL       12'h0403
`define OPC_ADD_B        12'h0404
`define OPC_ADD_BL       12'h0405
`define OPC_ADD_BC       12'h0406
`define OPC_ADD_BCL      12'h0407
`define OPC_SUB          12'h0410
`define OPC_SUB_L        12'h0411
`define OPC_SUB_C        12'h0412
`define OPC_SUB_CL       12'h0413
`define OPC_SUB_B        12'h0414
`define OPC_SUB_BL       12'h0415
`define OPC_SUB_BC       12'h0416
`define WORD_W           16
`define DIGIT_W          4
`define DIGIT_CNT_W      3
`define LAST_DIGIT_ONE   3'h3
`define LAST_DIGIT_TWO   3'h7
`define DEC_MAX          4'h9
`define DEC_MAX_SUM      5'h09
`define DEC_ADJUST       5'h06
`define WORD_RESET       16'h0000
`endif

// ### add_sub_pkg.sv
// Types of the binary and decimal add and subtract unit.
package add_sub_pkg;
  typedef struct packed {
    logic valid;
    logic wide;
    logic decimal;
    logic sub;
    logic use_carry;
  } op_ctrl_s;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_FIN
  } unit_state_e;
endpackage

// ### add_sub_link_if.sv
// Links the unit core with its decoder and its digit slice.
`timescale 1ns/10ps
`include "add_sub_cfg.svh"
interface add_sub_link_if;
  import add_sub_pkg::*;
  logic [`OPC_W-1:0]   code;
  op_ctrl_s            ctrl;
  logic [`DIGIT_W-1:0] dig_a;
  logic [`DIGIT_W-1:0] dig_b;
  logic                dig_cin;
  logic                dig_decimal;
  logic                dig_sub;
  logic [`DIGIT_W-1:0] dig_sum;
  logic                dig_cout;
  modport core (output code, input ctrl, output dig_a, output dig_b, output dig_cin,
                output dig_decimal, output dig_sub, input dig_sum, input dig_cout);
  modport decode (input code, output ctrl);
  modport digit (input dig_a, input dig_b, input dig_cin, input dig_decimal,
                 input dig_sub, output dig_sum, output dig_cout);
endinterface

// ### op_decoder.sv
// Decodes an operation code into width, number system and carry usage.
`timescale 1ns/10ps
`include "add_sub_cfg.svh"
module op_decoder
  import add_sub_pkg::*;
(
  add_sub_link_if.decode lnk
);
  // Fields: valid, wide, decimal, sub, use_carry.
  always_comb
  begin
    lnk.ctrl = '0;
    unique case (lnk.code)
      `OPC_ADD:     lnk.ctrl = 5'h10;
      `OPC_ADD_L:   lnk.ctrl = 5'h18;
      `OPC_ADD_C:   lnk.ctrl = 5'h11;
      `OPC_ADD_CL:  lnk.ctrl = 5'h19;
      `OPC_ADD_B:   lnk.ctrl = 5'h14;
      `OPC_ADD_BL:  lnk.ctrl = 5'h1C;
      `OPC_ADD_BC:  lnk.ctrl = 5'h15;
      `OPC_ADD_BCL: lnk.ctrl = 5'h1D;
      `OPC_SUB:     lnk.ctrl = 5'h12;
      `OPC_SUB_L:   lnk.ctrl = 5'h1A;
      `OPC_SUB_C:   lnk.ctrl = 5'h13;
      `OPC_SUB_CL:  lnk.ctrl = 5'h1B;
      `OPC_SUB_B:   lnk.ctrl = 5'h16;
      `OPC_SUB_BL:  lnk.ctrl = 5'h1E;
      `OPC_SUB_BC:  lnk.ctrl = 5'h17;
      default:      lnk.ctrl = '0;
    endcase
  end
endmodule

// ### digit_slice.sv
// One four-bit digit of binary or decimal add and subtract.
`timescale 1ns/10ps
`include "add_sub_cfg.svh"
module digit_slice
  import add_sub_pkg::*;
(
  add_sub_link_if.digit lnk
);
  logic [`DIGIT_W-1:0] term_b;
  logic [4:0]          raw;
  logic [4:0]          adj;
  // Subtraction adds the nines or ones complement; carry out means no borrow.
  always_comb
  begin
    if (lnk.dig_sub)
      term_b = lnk.dig_decimal ? (`DEC_MAX - lnk.dig_b) : ~lnk.dig_b;
    else
      term_b = lnk.dig_b;
    raw = {1'b0, lnk.dig_a} + {1'b0, term_b} + {4'h0, lnk.dig_cin};
    adj = raw + `DEC_ADJUST;
    if (lnk.dig_decimal && (raw > `DEC_MAX_SUM))
    begin
      lnk.dig_sum  = adj[3:0];
      lnk.dig_cout = 1'b1;
    end
    else
    begin
      lnk.dig_sum  = raw[3:0];
      lnk.dig_cout = raw[4];
    end
  end
endmodule

// ### add_sub_unit.sv
// Digit-serial binary and decimal add and subtract unit with carry flag.
//
// Notes on behaviour
// - 400: 16-bit add, carry flag ignored.
// - 401: 32-bit add of word pairs.
// - 402: 16-bit add with carry in.
// - 403: 32-bit add with carry in.
// - 404: 4-digit decimal add, no carry in.
// - 405: 8-digit decimal add, no carry in.
// - 406: 4-digit decimal add with carry in.
// - 407: 8-digit decimal add with carry in.
// - 410: 16-bit subtract, no borrow in.
// - 411: 32-bit subtract, no borrow in.
// - 412: 16-bit subtract with borrow in.
// - 413: 32-bit subtract with borrow in.
// - 414: 4-digit decimal subtract, no borrow in.
// - 415: 8-digit decimal subtract, no borrow in.
// - 416: 4-digit decimal subtract with borrow in.
// - Additions set carry on overflow, else clear.
// - Subtractions set carry on borrow, else clear.
`timescale 1ns/10ps
`include "add_sub_cfg.svh"
module add_sub_unit
  import add_sub_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic                 start,
  input  wire logic [`OPC_W-1:0]    op_code,
  input  wire logic [`WORD_W-1:0]   left_lo,
  input  wire logic [`WORD_W-1:0]   left_hi,
  input  wire logic [`WORD_W-1:0]   right_lo,
  input  wire logic [`WORD_W-1:0]   right_hi,
  output logic [`WORD_W-1:0]        result_lo_q,
  output logic [`WORD_W-1:0]        result_hi_q,
  output logic                      carry_flag_q,
  output logic                      done_q,
  output logic                      busy_q,
  output logic                      illegal_q,
  output logic                      bcd_error_q
);

  // ==========================================================================
  // Decoder and digit slice
  add_sub_link_if lnk ();

  op_decoder u_decoder
  (
    .lnk (lnk.decode)
  );

  digit_slice u_digit
  (
    .lnk (lnk.digit)
  );

  // ==========================================================================
  // Working state
  unit_state_e              state_q;
  op_ctrl_s                 ctrl_q;
  logic [2*`WORD_W-1:0]     left_q;
  logic [2*`WORD_W-1:0]     right_q;
  logic [2*`WORD_W-1:0]     acc_q;
  logic [`DIGIT_CNT_W-1:0]  digit_q;
  logic                     chain_q;
  logic                     take;
  logic                     last_digit;
  logic                     bcd_bad;
  logic                     cin_start;
  logic [2*`WORD_W-1:0]     left_in;
  logic [2*`WORD_W-1:0]     right_in;

  assign take     = (state_q == ST_IDLE) && start;
  assign left_in  = {left_hi, left_lo};
  assign right_in = {right_hi, right_lo};
  assign lnk.code = op_code;

  assign last_digit = ctrl_q.wide ? (digit_q == `LAST_DIGIT_TWO)
                                  : (digit_q == `LAST_DIGIT_ONE);

  // ==========================================================================
  // Decimal operand check
  function automatic logic bad_digits(input logic [2*`WORD_W-1:0] v, input logic wide);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if ((wide || (i < 4)) && (v[i*4 +: 4] > `DEC_MAX))
        bad = 1'b1;
    end
    return bad;
  endfunction

  assign bcd_bad = lnk.ctrl.decimal &&
                   (bad_digits(left_in, lnk.ctrl.wide) || bad_digits(right_in, lnk.ctrl.wide));

  // ==========================================================================
  // Initial carry into the lowest digit
  always_comb
  begin
    if (lnk.ctrl.use_carry)
      cin_start = lnk.ctrl.sub ? ~carry_flag_q : carry_flag_q;
    else
      cin_start = lnk.ctrl.sub;
  end

  // ==========================================================================
  // Digit slice feed
  always_comb
  begin
    lnk.dig_a       = left_q[`DIGIT_W-1:0];
    lnk.dig_b       = right_q[`DIGIT_W-1:0];
    lnk.dig_cin     = chain_q;
    lnk.dig_decimal = ctrl_q.decimal;
    lnk.dig_sub     = ctrl_q.sub;
  end

  // ==========================================================================
  // Sequencing
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (take)
            state_q <= (lnk.ctrl.valid && !bcd_bad) ? ST_RUN : ST_FIN;
        end
        ST_RUN:
        begin
          if (last_digit)
            state_q <= ST_FIN;
        end
        ST_FIN:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Operand capture and digit stepping
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q  <= '0;
      left_q  <= '0;
      right_q <= '0;
      acc_q   <= '0;
      digit_q <= '0;
      chain_q <= 1'b0;
    end
    else if (take)
    begin
      ctrl_q  <= lnk.ctrl;
      left_q  <= left_in;
      right_q <= right_in;
      acc_q   <= '0;
      digit_q <= '0;
      chain_q <= cin_start;
    end
    else if (state_q == ST_RUN)
    begin
      left_q  <= {4'h0, left_q[2*`WORD_W-1:`DIGIT_W]};
      right_q <= {4'h0, right_q[2*`WORD_W-1:`DIGIT_W]};
      acc_q   <= {lnk.dig_sum, acc_q[2*`WORD_W-1:`DIGIT_W]};
      digit_q <= digit_q + 3'h1;
      chain_q <= lnk.dig_cout;
    end
  end

  // ==========================================================================
  // Completion: results and carry flag change in one edge
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      result_lo_q  <= `WORD_RESET;
      result_hi_q  <= `WORD_RESET;
      carry_flag_q <= 1'b0;
    end
    else if ((state_q == ST_FIN) && ctrl_q.valid && !bcd_error_q)
    begin
      if (ctrl_q.wide)
      begin
        result_lo_q <= acc_q[`WORD_W-1:0];
        result_hi_q <= acc_q[2*`WORD_W-1:`WORD_W];
      end
      else
        result_lo_q <= acc_q[2*`WORD_W-1:`WORD_W];
      carry_flag_q <= ctrl_q.sub ? ~chain_q : chain_q;
    end
  end

  // ==========================================================================
  // Status
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      illegal_q   <= 1'b0;
      bcd_error_q <= 1'b0;
    end
    else if (take)
    begin
      illegal_q   <= !lnk.ctrl.valid;
      bcd_error_q <= lnk.ctrl.valid && bcd_bad;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      done_q <= (state_q == ST_FIN);
      busy_q <= take || ((state_q != ST_IDLE) && (state_q != ST_FIN));
    end
  end

endmodule

// ### add_sub_asserts.sv
// Checker of the add and subtract unit.
`timescale 1ns/10ps
`include "add_sub_cfg.svh"
module add_sub_asserts (
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic              start,
  input wire logic [`OPC_W-1:0] op_code,
  input wire logic [15:0]       left_lo,
  input wire logic [15:0]       left_hi,
  input wire logic [15:0]       right_lo,
  input wire logic [15:0]       right_hi,
  input wire logic [15:0]       result_lo_q,
  input wire logic [15:0]       result_hi_q,
  input wire logic              carry_flag_q,
  input wire logic              done_q,
  input wire logic              busy_q,
  input wire logic              illegal_q,
  input wire logic              bcd_error_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic tk;
  assign tk = start && !busy_q;
  chk_add_single: assert property (tk && op_code == `OPC_ADD |-> ##6
    {carry_flag_q, result_lo_q} == {1'b0, $past(left_lo, 6)} + $past(right_lo, 6))
    else $error("single sum wrong");
  chk_addc_single: assert property (tk && op_code == `OPC_ADD_C |-> ##6
    {carry_flag_q, result_lo_q} == {1'b0, $past(left_lo, 6)} + $past(right_lo, 6)
    + $past(carry_flag_q, 6)) else $error("carry sum wrong");
  chk_sub_single: assert property (tk && op_code == `OPC_SUB |-> ##6
    {carry_flag_q, result_lo_q} == {1'b0, $past(left_lo, 6)} - $past(right_lo, 6))
    else $error("difference wrong");
  chk_add_double: assert property (tk && op_code == `OPC_ADD_L |-> ##10
    {carry_flag_q, result_hi_q, result_lo_q} == {1'b0, $past(left_hi, 10),
    $past(left_lo, 10)} + {$past(right_hi, 10), $past(right_lo, 10)})
    else $error("double sum wrong");
  chk_sub_double: assert property (tk && op_code == `OPC_SUB_L |-> ##10
    {carry_flag_q, result_hi_q, result_lo_q} == {1'b0, $past(left_hi, 10),
    $past(left_lo, 10)} - {$past(right_hi, 10), $past(right_lo, 10)})
    else $error("double difference wrong");
  chk_done_time: assert property (tk && op_code inside {`OPC_ADD, `OPC_SUB}
    |-> ##1 !done_q [*5] ##1 done_q) else $error("done late or early");
  chk_done_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  chk_update_done: assert property ($changed(result_lo_q) ||
    $changed(result_hi_q) || $changed(carry_flag_q) |-> done_q)
    else $error("result without done");
  chk_busy_start: assert property (tk |=> busy_q)
    else $error("busy missing after start");
  chk_bcd_keep: assert property ($rose(bcd_error_q) |=> $stable(result_lo_q) &&
    $stable(carry_flag_q)) else $error("result written on bad digits");
endmodule
bind add_sub_unit add_sub_asserts u_add_sub_asserts (.clock(clock), .reset_n(reset_n),
  .start(start), .op_code(op_code), .left_lo(left_lo), .left_hi(left_hi),
  .right_lo(right_lo), .right_hi(right_hi), .result_lo_q(result_lo_q),
  .result_hi_q(result_hi_q), .carry_flag_q(carry_flag_q), .done_q(done_q),
  .busy_q(busy_q), .illegal_q(illegal_q), .bcd_error_q(bcd_error_q));

// ### seq_model.sv
// Model of the instruction sequencer that feeds the unit.
`timescale 1ns/10ps
`include "add_sub_cfg.svh"
module seq_model (
  input  wire logic              clock,
  input  wire logic              go,
  input  wire logic [`OPC_W-1:0] op_in,
  input  wire logic [31:0]       a_in,
  input  wire logic [31:0]       b_in,
  input  wire logic              done_q,
  output logic                   start,
  output logic [`OPC_W-1:0]      op_code,
  output logic [31:0]            left_w,
  output logic [31:0]            right_w
);
  initial
  begin
    start = 0;
    op_code = 0;
    left_w = 0;
    right_w = 0;
  end
  // Operands come with start and stand until done, then are inverted.
  always @(negedge clock)
  begin
    start <= go;
    if (go)
    begin
      op_code <= op_in;
      left_w <= a_in;
      right_w <= b_in;
    end
    else if (done_q)
    begin
      left_w <= ~left_w;
      right_w <= ~right_w;
    end
  end
endmodule

// ### binary_bcd_add_sub_unit_bench.sv
// Testbench of the add and subtract unit.
`timescale 1ns/10ps
`include "add_sub_cfg.svh"
module binary_bcd_add_sub_unit_bench;
  logic        clock = 0;
  logic        reset_n = 0;
  logic        go = 0;
  logic [11:0] op_in = 0;
  logic [31:0] a_in = 0;
  logic [31:0] b_in = 0;
  logic        start;
  logic [11:0] op_code;
  logic [31:0] left_w;
  logic [31:0] right_w;
  logic [15:0] lo;
  logic [15:0] hi;
  logic        cy;
  logic        done_q;
  logic        ill;
  logic        bcd;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #50 clock = ~clock;
  seq_model u_seq_model (.clock(clock), .go(go), .op_in(op_in), .a_in(a_in),
    .b_in(b_in), .done_q(done_q), .start(start), .op_code(op_code),
    .left_w(left_w), .right_w(right_w));
  add_sub_unit u_add_sub_unit (.clock(clock), .reset_n(reset_n), .start(start),
    .op_code(op_code), .left_lo(left_w[15:0]), .left_hi(left_w[31:16]),
    .right_lo(right_w[15:0]), .right_hi(right_w[31:16]), .result_lo_q(lo),
    .result_hi_q(hi), .carry_flag_q(cy), .done_q(done_q), .busy_q(),
    .illegal_q(ill), .bcd_error_q(bcd));
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Issues one operation, waits for done and compares done, carry and result.
  task automatic run(input logic [11:0] op, input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] ex, input logic c);
    int n;
    n = 0;
    @(negedge clock);
    go <= 1;
    op_in <= op;
    a_in <= a;
    b_in <= b;
    @(negedge clock);
    go <= 0;
    while (done_q !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    if (op[0])
      chk({done_q, cy, hi, lo}, {1'b1, c, ex});
    else
      chk({done_q, cy, lo}, {1'b1, c, ex[15:0]});
  endtask
  task automatic s_bin_add;
    run(`OPC_ADD, 16'hFFFF, 16'h0001, 16'h0000, 1'b1);
    run(`OPC_ADD, 16'h7FFF, 16'h0001, 16'h8000, 1'b0);
    run(`OPC_ADD, 16'hFFFF, 16'h0001, 16'h0000, 1'b1);
    run(`OPC_ADD_C, 16'h0001, 16'h0001, 16'h0003, 1'b0);
    run(`OPC_ADD_L, 32'h0000_FFFF, 32'h0000_0001, 32'h0001_0000, 1'b0);
    run(`OPC_ADD, 16'hFFFF, 16'h0001, 16'h0000, 1'b1);
    run(`OPC_ADD_CL, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 1'b1);
  endtask
  task automatic s_bin_sub;
    run(`OPC_SUB, 16'h0000, 16'h0001, 16'hFFFF, 1'b1);
    run(`OPC_SUB_C, 16'h0005, 16'h0002, 16'h0002, 1'b0);
    run(`OPC_SUB_L, 32'h0001_0000, 32'h0000_0001, 32'h0000_FFFF, 1'b0);
    run(`OPC_SUB, 16'h0000, 16'h0001, 16'hFFFF, 1'b1);
    run(`OPC_SUB_CL, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
  endtask
  task automatic s_dec_add;
    run(`OPC_ADD_B, 16'h9999, 16'h0001, 16'h0000, 1'b1);
    run(`OPC_ADD_BC, 16'h0001, 16'h0001, 16'h0003, 1'b0);
    run(`OPC_ADD_BL, 32'h0000_9999, 32'h0000_0001, 32'h0001_0000, 1'b0);
    run(`OPC_ADD_B, 16'h9999, 16'h0001, 16'h0000, 1'b1);
    run(`OPC_ADD_BCL, 32'h9999_9999, 32'h0000_0000, 32'h0000_0000, 1'b1);
  endtask
  task automatic s_dec_sub;
    run(`OPC_SUB_B, 16'h0000, 16'h0001, 16'h9999, 1'b1);
    run(`OPC_SUB_BC, 16'h0005, 16'h0002, 16'h0002, 1'b0);
    run(`OPC_SUB_BL, 32'h0001_0000, 32'h0000_0001, 32'h0000_9999, 1'b0);
  endtask
  task automatic s_illegal;
    run(12'h0417, 16'h0001, 16'h0001, 32'h0000_9999, 1'b0);
    chk(ill, 1'b1);
    run(`OPC_ADD_B, 16'h00A0, 16'h0001, 32'h0000_9999, 1'b0);
    chk({ill, bcd}, 2'h1);
    run(`OPC_ADD_B, 16'h0001, 16'h0001, 32'h0000_0002, 1'b0);
    chk(bcd, 1'b0);
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      results;
    end
  end
  initial
  begin
    repeat (6) @(negedge clock);
    reset_n = 1;
    s_bin_add;
    s_bin_sub;
    s_dec_add;
    s_dec_sub;
    s_illegal;
    results;
  end
endmodule
